//--- inc/ces_pkg.sv
// Shared constants and types for the CPU exception sequencer.
// Assumes one 200 MHz clock and a 32-bit AXI4-Lite register port.
package ces_pkg;

	// ==========================================================
	// Clock
	localparam int CLK_MHZ = 200;

	// ==========================================================
	// Vector numbers
	localparam logic [5:0] VEC_RESET = 6'h00;
	localparam logic [5:0] VEC_NMI = 6'h07;
	localparam logic [5:0] VEC_TRAP_BASE = 6'h08;
	localparam logic [5:0] VEC_IRQ_BASE = 6'h0c;
	localparam logic [5:0] VEC_PERI_MIN = 6'h14;
	localparam logic [5:0] VEC_PERI_MAX = 6'h3c;

	// ==========================================================
	// Condition code layout and values
	localparam int CCR_I_BIT = 7;
	localparam int CCR_UI_BIT = 6;
	localparam logic [7:0] CCR_I_MASK = 8'h80;
	localparam logic [7:0] CCR_UI_MASK = 8'h40;
	localparam logic [7:0] CCR_RST = 8'h80;

	// ==========================================================
	// Register map (byte addresses) and fields
	localparam int AXI_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_VEC = 8'h08;
	localparam int CTRL_UE_BIT = 0;
	localparam int CTRL_LVL_LSB = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_3f01;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ==========================================================
	// Sequencer states, Gray along run -> push -> fetch -> load in advanced mode
	typedef enum logic [2:0] {
		ST_RUN = 3'h0,
		ST_PUSH_HI = 3'h1,
		ST_PUSH_LO = 3'h3,
		ST_VEC_HI = 3'h2,
		ST_VEC_LO = 3'h6,
		ST_LOAD = 3'h7,
		ST_RESET = 3'h5
	} ces_state_t;

endpackage

//--- rtl/ces_exception_seq.sv
// Exception sequencer: ranks reset, interrupts and traps, saves context,
// fetches the vector and hands the new PC, CONDITION_CODE_REGISTER and SP to the core.
// Assumes a core that halts while cpu_hold is high and a word-wide memory
// port with a level request held until the acknowledge.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none

module ces_exception_seq (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic chip_clear_pin_n,
	input wire logic watchdog_ovf,
	input wire logic adv_mode_pin,
	input wire logic insn_done,
	input wire logic trap_instruction,
	input wire logic [1:0] trap_sel,
	input wire logic [23:0] pc_in,
	input wire logic [7:0] ccr_in,
	input wire logic [23:0] sp_in,
	input wire logic nmi_req,
	input wire logic [5:0] irq_req,
	input wire logic periph_req,
	input wire logic [5:0] periph_vec,
	input wire logic periph_lvl,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	output logic cpu_hold,
	output logic mem_req,
	output logic mem_we,
	output logic [23:0] mem_addr,
	output logic [15:0] mem_wdata,
	output logic exc_load,
	output logic [23:0] new_pc,
	output logic [7:0] new_ccr,
	output logic [23:0] new_sp,
	output logic int_ack,
	output logic [5:0] int_ack_vec,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ==========================================================
	// Functions
	// Word accesses ignore the lowest address bit
	function automatic logic [23:0] word_addr(input logic [23:0] a);
		word_addr = {a[23:1], 1'b0};
	endfunction

	// Table slot of a vector: four bytes advanced, two bytes normal
	function automatic logic [23:0] vec_addr(input logic [5:0] v, input logic adv);
		vec_addr = adv ? {16'h0000, v, 2'b00} : {17'h00000, v, 1'b0};
	endfunction

	// Lowest set request line wins inside one level
	function automatic logic [5:0] first_set(input logic [5:0] r);
		first_set = 6'h00;
		for (int i = 5; i >= 0; i--) begin
			if (r[i]) begin
				first_set = 6'(i);
			end
		end
	endfunction

	// ==========================================================
	// Pin synchronisers and internal reset
	logic clr_s1_q, clr_s2_q, clr_s3_q, clr_lvl_q;
	logic adv_s1_q, adv_s2_q, adv_s3_q, adv_lvl_q, adv_q;
	wire logic rst_int, adv_lvl_d;

	// Three stages; a level counts once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clr_s1_q <= 1'b0;
			clr_s2_q <= 1'b0;
			clr_s3_q <= 1'b0;
			clr_lvl_q <= 1'b0;
			adv_s1_q <= 1'b0;
			adv_s2_q <= 1'b0;
			adv_s3_q <= 1'b0;
			adv_lvl_q <= 1'b0;
		end else begin
			clr_s1_q <= chip_clear_pin_n;
			clr_s2_q <= clr_s1_q;
			clr_s3_q <= clr_s2_q;
			if (clr_s2_q == clr_s3_q) clr_lvl_q <= clr_s3_q;
			adv_s1_q <= adv_mode_pin;
			adv_s2_q <= adv_s1_q;
			adv_s3_q <= adv_s2_q;
			adv_lvl_q <= adv_lvl_d;
		end
	end

	// Low pin, bus reset or watchdog overflow all mean reset state
	assign rst_int = !aresetn || !clr_lvl_q || watchdog_ovf;

	// Mode strap is caught only while the chip sits in reset; the next
	// filtered level is used so the last reset cycle sees the settled strap
	assign adv_lvl_d = (adv_s2_q == adv_s3_q) ? adv_s3_q : adv_lvl_q;
	always_ff @(posedge aclk) begin
		if (rst_int) adv_q <= adv_lvl_d;
	end

	// ==========================================================
	// Control register fields
	logic [31:0] ctrl_q;
	wire logic ue_w;
	wire logic [5:0] irq_lvl_w;
	assign ue_w = ctrl_q[ces_pkg::CTRL_UE_BIT];
	assign irq_lvl_w = ctrl_q[ces_pkg::CTRL_LVL_LSB +: 6];

	// ==========================================================
	// Sequencer state
	ces_pkg::ces_state_t state_q;
	logic [5:0] vec_q;
	logic [23:0] pc_sv_q;
	logic [1:0] trap_sel_q;
	logic block_q, after_seq_q, nmi_pend_q, trap_pend_q, nmi_seen_q;

	// Context source: fresh values straight after a sequence
	wire logic [23:0] pc_src, sp_src, sp_push;
	wire logic [7:0] ccr_src;
	assign pc_src = after_seq_q ? new_pc : pc_in;
	assign ccr_src = after_seq_q ? new_ccr : ccr_in;
	assign sp_src = after_seq_q ? new_sp : sp_in;
	assign sp_push = word_addr(sp_src - 24'h000004);

	// ==========================================================
	// Interrupt arbitration
	wire logic [5:0] irq_l1, irq_l0, int_vec_w, trap_vec_w;
	wire logic per_ok, per_l1, per_l0, mask_all, mask_l0, int_ok;
	wire logic boundary, take_int, trap_set, take_trap;
	wire logic [7:0] ccr_set;
	assign irq_l1 = irq_req & irq_lvl_w;
	assign irq_l0 = irq_req & ~irq_lvl_w;
	assign per_ok = periph_req && periph_vec >= ces_pkg::VEC_PERI_MIN
		&& periph_vec <= ces_pkg::VEC_PERI_MAX;
	assign per_l1 = per_ok && periph_lvl;
	assign per_l0 = per_ok && !periph_lvl;
	// UI is a second mask only while the enable bit is clear
	assign mask_all = ccr_src[ces_pkg::CCR_I_BIT];
	assign mask_l0 = mask_all || (!ue_w && ccr_src[ces_pkg::CCR_UI_BIT]);
	// NMI first, then level one, then level zero; pins before peripherals
	assign int_ok = nmi_pend_q || (!mask_all && (|irq_l1 || per_l1))
		|| (!mask_l0 && (|irq_l0 || per_l0));
	assign int_vec_w = nmi_pend_q ? ces_pkg::VEC_NMI :
		(!mask_all && |irq_l1) ? ces_pkg::VEC_IRQ_BASE + first_set(irq_l1) :
		(!mask_all && per_l1) ? periph_vec :
		(|irq_l0) ? ces_pkg::VEC_IRQ_BASE + first_set(irq_l0) :
		periph_vec;
	assign boundary = insn_done || after_seq_q;
	// Blocking lifts as the first instruction completes
	assign take_int = state_q == ces_pkg::ST_RUN && boundary && int_ok
		&& !(block_q && !insn_done);
	assign trap_set = state_q == ces_pkg::ST_RUN && trap_instruction;
	assign take_trap = state_q == ces_pkg::ST_RUN && !take_int
		&& (trap_set || trap_pend_q);
	assign trap_vec_w = ces_pkg::VEC_TRAP_BASE
		+ {4'h0, (trap_set ? trap_sel : trap_sel_q)};
	assign ccr_set = ccr_src | ces_pkg::CCR_I_MASK
		| (ue_w ? 8'h00 : ces_pkg::CCR_UI_MASK);

	// ==========================================================
	// Pending flags; a new event beats a same-cycle clear
	always_ff @(posedge aclk) begin
		if (rst_int) begin
			nmi_pend_q <= 1'b0;
			nmi_seen_q <= 1'b0;
			trap_pend_q <= 1'b0;
			trap_sel_q <= 2'b00;
		end else begin
			nmi_seen_q <= nmi_req;
			nmi_pend_q <= (nmi_req && !nmi_seen_q) || (nmi_pend_q
				&& !(take_int && int_vec_w == ces_pkg::VEC_NMI));
			trap_pend_q <= (trap_set || trap_pend_q) && !take_trap; // Held pending while an interrupt wins, cleared once taken
			if (trap_set) trap_sel_q <= trap_sel;
		end
	end

	// ==========================================================
	// Entry sequence
	wire logic ack_w;
	assign ack_w = mem_ack && mem_req;

	always_ff @(posedge aclk) begin
		if (rst_int) begin
			state_q <= ces_pkg::ST_RESET;
			vec_q <= ces_pkg::VEC_RESET;
			pc_sv_q <= 24'h000000;
			block_q <= 1'b1;
			after_seq_q <= 1'b0;
			cpu_hold <= 1'b1;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 24'h000000;
			mem_wdata <= 16'h0000;
			exc_load <= 1'b0;
			new_pc <= 24'h000000;
			new_ccr <= ces_pkg::CCR_RST;
			new_sp <= 24'h000000;
			int_ack <= 1'b0;
			int_ack_vec <= 6'h00;
		end else begin
			exc_load <= 1'b0;
			int_ack <= 1'b0;
			after_seq_q <= 1'b0;
			if (insn_done) block_q <= 1'b0;
			unique case (state_q)
				// Reset path: no stack, fetch the vector at once
				ces_pkg::ST_RESET: begin
					new_ccr <= ces_pkg::CCR_RST;
					vec_q <= ces_pkg::VEC_RESET;
					mem_req <= 1'b1;
					mem_we <= 1'b0;
					mem_addr <= word_addr(vec_addr(ces_pkg::VEC_RESET, adv_q));
					state_q <= adv_q ? ces_pkg::ST_VEC_HI : ces_pkg::ST_VEC_LO;
				end
				ces_pkg::ST_RUN: begin
					if (take_int || take_trap) begin
						vec_q <= take_int ? int_vec_w : trap_vec_w;
						int_ack <= take_int && int_vec_w != ces_pkg::VEC_NMI;
						int_ack_vec <= int_vec_w;
						pc_sv_q <= pc_src;
						new_ccr <= ccr_set;
						new_sp <= sp_push;
						cpu_hold <= 1'b1;
						// Upper word: CONDITION_CODE_REGISTER and PC bits 23:16 in advanced mode, zero byte in normal mode
						mem_req <= 1'b1;
						mem_we <= 1'b1;
						mem_addr <= sp_push;
						mem_wdata <= {ccr_src, (adv_q ? pc_src[23:16] : 8'h00)};
						state_q <= ces_pkg::ST_PUSH_HI;
					end
				end
				ces_pkg::ST_PUSH_HI: begin
					if (ack_w) begin
						mem_addr <= word_addr(new_sp + 24'h000002);
						mem_wdata <= pc_sv_q[15:0];
						state_q <= ces_pkg::ST_PUSH_LO;
					end
				end
				ces_pkg::ST_PUSH_LO: begin
					if (ack_w) begin
						mem_we <= 1'b0;
						mem_addr <= word_addr(vec_addr(vec_q, adv_q));
						state_q <= adv_q ? ces_pkg::ST_VEC_HI : ces_pkg::ST_VEC_LO;
					end
				end
				ces_pkg::ST_VEC_HI: begin
					if (ack_w) begin
						new_pc[23:16] <= mem_rdata[7:0];
						mem_addr <= word_addr(vec_addr(vec_q, adv_q) + 24'h000002);
						state_q <= ces_pkg::ST_VEC_LO;
					end
				end
				ces_pkg::ST_VEC_LO: begin
					if (ack_w) begin
						if (!adv_q) new_pc[23:16] <= 8'h00;
						new_pc[15:0] <= mem_rdata;
						mem_req <= 1'b0;
						state_q <= ces_pkg::ST_LOAD;
					end
				end
				// Hand over; except after reset, the next cycle is a boundary and a pending NMI enters again at once, as the new CCR masks the rest
				ces_pkg::ST_LOAD: begin
					exc_load <= 1'b1;
					cpu_hold <= 1'b0;
					after_seq_q <= !block_q;
					state_q <= ces_pkg::ST_RUN;
				end
				default: begin
					state_q <= ces_pkg::ST_RESET;
				end
			endcase
		end
	end

	// ==========================================================
	// AXI4-Lite slave; handshake state lives on the bus reset only
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic aw_got_q, w_got_q;
	wire logic aw_hs, w_hs, wr_go, ar_hs, wr_ctrl, wr_hit, rd_hit;
	wire logic [31:0] bmask, stat_w, rd_mux;
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	assign wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	assign wr_ctrl = wr_go && aw_addr_q == ces_pkg::REG_CTRL;
	assign wr_hit = aw_addr_q == ces_pkg::REG_CTRL || aw_addr_q == ces_pkg::REG_STAT
		|| aw_addr_q == ces_pkg::REG_VEC;
	assign rd_hit = s_axi_araddr == ces_pkg::REG_CTRL || s_axi_araddr == ces_pkg::REG_STAT
		|| s_axi_araddr == ces_pkg::REG_VEC;
	assign bmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}},
		{8{w_strb_q[0]}}} & ces_pkg::CTRL_WMASK;
	// Status: sequencer state and pending conditions
	assign stat_w = {24'h000000, adv_q, block_q, nmi_pend_q, trap_pend_q,
		cpu_hold, state_q};
	assign rd_mux = s_axi_araddr == ces_pkg::REG_CTRL ? ctrl_q :
		s_axi_araddr == ces_pkg::REG_STAT ? stat_w :
		s_axi_araddr == ces_pkg::REG_VEC ? {26'h0000000, vec_q} : 32'h00000000;

	// Control register is held at its initial value during chip reset
	always_ff @(posedge aclk) begin
		if (rst_int) begin
			ctrl_q <= ces_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= (ctrl_q & ~bmask) | (w_data_q & bmask);
		end
	end

	// Address and data taken in either order; answer after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ces_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_got_q && !aw_hs;
			s_axi_wready <= !w_got_q && !w_hs;
			if (aw_hs) begin
				aw_got_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_hs) begin
				w_got_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? ces_pkg::RESP_OKAY : ces_pkg::RESP_DECERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Read: one outstanding, ready drops until the data is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= ces_pkg::RESP_OKAY;
		end else begin
			if (ar_hs) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? ces_pkg::RESP_OKAY : ces_pkg::RESP_DECERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // ces_exception_seq

`default_nettype wire

//--- verification/ces_mem_model.sv
// Word memory behind the sequencer's port, with an access log.
// Assumes one level request held until the acknowledge.
`timescale 1ns/100ps
`default_nettype none
module ces_mem_model (
	input wire logic aclk,
	input wire logic clr,
	input wire logic [1:0] slow,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [23:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic mem_ack,
	output logic [15:0] mem_rdata
);
	// ==========================================
	// Log of taken accesses, cleared by clr
	logic [23:0] la [8];
	logic [15:0] ld [8];
	logic [3:0] n = 4'h0;
	logic [1:0] w = 2'h0;
	logic [2:0] i;
	assign i = clr ? 3'h0 : n[2:0];
	// Read data only valid in the ack cycle, else toggles
	always_ff @(posedge aclk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (clr)
			n <= 4'h0;
		if (mem_req && !mem_ack) begin
			if (w == slow) begin
				mem_ack <= 1'b1;
				w <= 2'h0;
				mem_rdata <= 16'h4000 | mem_addr[15:0];
				la[i] <= mem_addr;
				ld[i] <= mem_wdata;
				n <= {1'b0, i} + 4'h1;
			end else
				w <= w + 2'h1;
		end
	end
endmodule // ces_mem_model
`default_nettype wire

//--- verification/ces_seq_chk_asserts.sv
// Protocol checks on the exception sequencer's ports.
// Assumes one clock domain and the bind at the foot.
`timescale 1ns/100ps
`default_nettype none
module ces_seq_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic chip_clear_pin_n,
	input wire logic watchdog_ovf,
	input wire logic insn_done,
	input wire logic mem_req,
	input wire logic mem_ack,
	input wire logic mem_we,
	input wire logic [23:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic cpu_hold,
	input wire logic exc_load,
	input wire logic [7:0] new_ccr,
	input wire logic int_ack,
	input wire logic [5:0] int_ack_vec
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================
	// Reset seen, first instruction not yet done
	logic blk_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || watchdog_ovf || !chip_clear_pin_n)
			blk_q <= 1'b1;
		else if (insn_done)
			blk_q <= 1'b0;
	end
	// ==========================================
	// Properties
	property p_wd; watchdog_ovf |=> cpu_hold && !mem_req && !exc_load && new_ccr == 8'h80; endproperty
	a_wd: assert property (p_wd) else $error("watchdog reset state wrong");
	property p_even; mem_req |-> !mem_addr[0]; endproperty
	a_even: assert property (p_even) else $error("odd memory address");
	property p_stab; mem_req && !mem_ack && !watchdog_ovf |=> mem_req && $stable(mem_addr)
		&& $stable(mem_we) && $stable(mem_wdata); endproperty
	a_stab: assert property (p_stab) else $error("request changed before ack");
	property p_bnd; int_ack |-> $past(insn_done) || $past(exc_load); endproperty
	a_bnd: assert property (p_bnd) else $error("interrupt taken off a boundary");
	property p_blk; blk_q && !insn_done |=> !int_ack && !mem_we; endproperty
	a_blk: assert property (p_blk) else $error("interrupt before first instruction");
	property p_rst; blk_q && mem_req |-> !mem_we && mem_addr[23:2] == 22'h0; endproperty
	a_rst: assert property (p_rst) else $error("reset sequence access wrong");
	property p_clrs; $rose(chip_clear_pin_n) |-> ##[1:12] mem_req; endproperty
	a_clrs: assert property (p_clrs) else $error("no vector fetch after clear");
	property p_clrh; !chip_clear_pin_n [*8] |-> cpu_hold && !mem_req && !exc_load; endproperty
	a_clrh: assert property (p_clrh) else $error("activity while clear pin low");
	property p_ld; exc_load |-> new_ccr[7] && !cpu_hold; endproperty
	a_ld: assert property (p_ld) else $error("load without mask or held");
	property p_vec; int_ack |-> int_ack_vec inside {[12:17], [20:60]}; endproperty
	a_vec: assert property (p_vec) else $error("interrupt vector out of range");
endmodule // ces_seq_chk
bind ces_exception_seq ces_seq_chk u_chk (.*);
`default_nettype wire

//--- verification/testbench.sv
// Directed bench for the exception sequencer.
// Assumes the memory model answers the word port; AXI4-Lite for CTRL.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic aclk, aresetn, chip_clear_pin_n, watchdog_ovf, adv_mode_pin, insn_done;
	logic trap_instruction, nmi_req, periph_req, periph_lvl, mem_ack, cpu_hold;
	logic mem_req, mem_we, exc_load, int_ack, clr;
	logic [1:0] trap_sel, slow, s_axi_bresp, s_axi_rresp;
	logic [23:0] pc_in, sp_in, new_pc, new_sp, mem_addr;
	logic [7:0] ccr_in, new_ccr, s_axi_awaddr, s_axi_araddr;
	logic [5:0] irq_req, periph_vec, int_ack_vec;
	logic [15:0] mem_rdata, mem_wdata;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	int error_cnt, n_checks;
	ces_exception_seq dut (.*);
	ces_mem_model mem (.*);
	// ==========================================
	// Clock
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// ==========================================
	// Checking and closing
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic results();
		if (error_cnt == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic tmo(input int i);
		if (i >= 300) begin
			error_cnt++;
			$display("CHECK FAILED %0t timeout", $time);
			results();
		end
	endtask
	// ==========================================
	// AXI4-Lite master, one transfer at a time
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		i = 0;
		do begin
			@(posedge aclk);
			i++;
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && i < 300);
		tmo(i);
		chk(s_axi_bresp, ces_pkg::RESP_OKAY);
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		i = 0;
		do begin
			@(posedge aclk);
			i++;
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && i < 300);
		tmo(i);
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, r);
	endtask
	// ==========================================
	// Core side: boundary pulse, optional trap
	task automatic kick(input logic t, input logic [1:0] s);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		insn_done <= 1'b1;
		trap_instruction <= t;
		trap_sel <= s;
		@(posedge aclk);
		insn_done <= 1'b0;
		trap_instruction <= 1'b0;
	endtask
	// Waits for the load; the bench drops the pin or peripheral request once acknowledged
	task automatic seq(input logic [5:0] v, input logic wr, input logic [7:0] c);
		logic [23:0] va;
		logic [2:0] k;
		int i;
		va = adv_mode_pin ? {16'h0, v, 2'h0} : {17'h0, v, 1'b0};
		k = wr ? 3'h2 : 3'h0;
		i = 0;
		do begin
			@(posedge aclk);
			i++;
			if (int_ack === 1'b1) begin
				irq_req <= irq_req & ~(6'h1 << (int_ack_vec - 6'hc));
				if (int_ack_vec >= 6'h14)
					periph_req <= 1'b0;
			end
		end while (exc_load !== 1'b1 && i < 300);
		tmo(i);
		chk(new_ccr, c);
		chk(mem.n, k + (adv_mode_pin ? 3'h2 : 3'h1));
		chk(mem.la[k], va);
		chk(new_pc, adv_mode_pin ? {va[7:0], 16'h4000 | va[15:0] + 16'h2} : {8'h0, 16'h4000 | va[15:0]});
		if (wr) begin
			chk(mem.la[0], sp_in - 24'h4);
			chk(mem.ld[0], {ccr_in, adv_mode_pin ? pc_in[23:16] : 8'h0});
			chk(mem.la[1], sp_in - 24'h2);
			chk(mem.ld[1], pc_in[15:0]);
			chk(new_sp, sp_in - 24'h4);
		end
	endtask
	// ==========================================
	// Main sequence
	initial begin
		int j;
		logic [5:0] ev [3];
		ev = '{6'h11, 6'hd, 6'h14};
		{aresetn, watchdog_ovf, insn_done, trap_instruction, trap_sel, nmi_req} = '0;
		{chip_clear_pin_n, adv_mode_pin, clr, slow, ccr_in, irq_req} = {3'h7, 16'h0};
		{periph_req, periph_vec, periph_lvl, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		pc_in = 24'h12_3456;
		sp_in = 24'h00_ff00;
		error_cnt = 0;
		n_checks = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		clr <= 1'b0;
		seq(6'h0, 1'b0, 8'h80);
		axr(ces_pkg::REG_CTRL, ces_pkg::CTRL_RST, ces_pkg::RESP_OKAY);
		axr(8'h0c, 32'h0, ces_pkg::RESP_DECERR);
		// Both requests wait for the first boundary, then the nonmaskable wins under mask
		nmi_req <= 1'b1;
		ccr_in <= 8'h80;
		irq_req <= 6'h01;
		repeat (8) @(posedge aclk);
		chk(cpu_hold, 1'b0);
		kick(1'b0, 2'h0);
		seq(6'h7, 1'b1, 8'h80);
		chk(int_ack_vec, 6'h7);
		nmi_req <= 1'b0;
		ccr_in <= 8'h00;
		kick(1'b0, 2'h0);
		seq(6'hc, 1'b1, 8'h80);
		// High level first, then pins before peripherals at the low level
		axw(ces_pkg::REG_CTRL, 32'h0000_2001);
		irq_req <= 6'h22;
		periph_req <= 1'b1;
		periph_vec <= 6'h14;
		for (j = 0; j < 3; j++) begin
			kick(1'b0, 2'h0);
			seq(ev[j], 1'b1, 8'h80);
			chk(int_ack_vec, ev[j]);
		end
		periph_req <= 1'b1;
		periph_vec <= 6'h3d;
		kick(1'b0, 2'h0);
		repeat (4) @(posedge aclk);
		chk(cpu_hold, 1'b0);
		periph_vec <= 6'h3c;
		kick(1'b0, 2'h0);
		seq(6'h3c, 1'b1, 8'h80);
		// Traps under full mask, slow memory, both user bit settings
		ccr_in <= 8'h80;
		slow <= 2'h2;
		for (j = 0; j < 4; j++) begin
			axw(ces_pkg::REG_CTRL, {31'h0, j[0]});
			kick(1'b1, j[1:0]);
			seq(6'h8 + j[5:0], 1'b1, j[0] ? 8'h80 : 8'hc0);
		end
		slow <= 2'h0;
		ccr_in <= 8'h00;
		// Watchdog reset in normal mode beats a pending pin request
		adv_mode_pin <= 1'b0;
		irq_req <= 6'h04;
		repeat (4) @(posedge aclk);
		watchdog_ovf <= 1'b1;
		clr <= 1'b1;
		@(posedge aclk);
		watchdog_ovf <= 1'b0;
		clr <= 1'b0;
		seq(6'h0, 1'b0, 8'h80);
		axr(ces_pkg::REG_CTRL, ces_pkg::CTRL_RST, ces_pkg::RESP_OKAY);
		kick(1'b0, 2'h0);
		seq(6'he, 1'b1, 8'h80);
		// Clear pin held low, then released in advanced mode
		adv_mode_pin <= 1'b1;
		chip_clear_pin_n <= 1'b0;
		clr <= 1'b1;
		repeat (12) @(posedge aclk);
		chk(cpu_hold, 1'b1);
		chip_clear_pin_n <= 1'b1;
		clr <= 1'b0;
		seq(6'h0, 1'b0, 8'h80);
		results();
	end
endmodule // testbench
`default_nettype wire
